// ==== fdg_pkg.sv ====
// fdg_pkg: constants for the fsk deviation / gaussian divider block
// assumes: registers reached over ahb-lite with 32-bit data
package fdg_pkg;
   // ==========================================================
   // register byte addresses (indices 0x1c..0x1f are register numbers,
   // not byte offsets, so index * 4 gives the byte address)
   localparam logic [7:0]  IDX_DEV_CFG    = 8'h1c;
   localparam logic [7:0]  IDX_DIV_LOW    = 8'h1d;
   localparam logic [7:0]  IDX_FILT_CFG   = 8'h1e;
   localparam logic [7:0]  IDX_STATUS     = 8'h1f;
   localparam logic [9:0]  ADDR_DEV_CFG   = {IDX_DEV_CFG, 2'b00};
   localparam logic [9:0]  ADDR_DIV_LOW   = {IDX_DIV_LOW, 2'b00};
   localparam logic [9:0]  ADDR_FILT_CFG  = {IDX_FILT_CFG, 2'b00};
   localparam logic [9:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};
   // ==========================================================
   // field positions
   localparam int          SCALE_LSB      = 5;
   localparam int          MULT_LSB       = 0;
   localparam int          BYP_BIT        = 3;
   localparam int          ASK_BIT        = 4;
   localparam int          STAT_GF_ON_BIT = 0;
   localparam int          STAT_TICK_BIT  = 1;
   // ==========================================================
   // reset values, widths and bus codes
   localparam logic [7:0]  RST_DEV_CFG    = 8'hdf;
   localparam logic [7:0]  RST_DIV_LOW    = 8'h08;
   localparam logic [7:0]  RST_FILT_CFG   = 8'h04;
   localparam logic [2:0]  SCALE_MUL2     = 3'h7;
   localparam int          DIV_W          = 11;
   localparam int          PROD_W         = 13;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;
endpackage : fdg_pkg

// ==== fdg_tick_if.sv ====
// fdg_tick_if: divider value into the strobe generator, strobe out
// assumes: one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface fdg_tick_if;
   logic [10:0] div_value;
   logic        run;
   logic        tick;
   modport ctrl (output div_value, output run, input tick);
   modport gen  (input div_value, input run, output tick);
endinterface : fdg_tick_if
`default_nettype wire

// ==== fdg_tick_gen.sv ====
// fdg_tick_gen: reloading down counter giving gaussian sample strobe
// assumes: div_value stable or changing only between periods
`timescale 1ns/1ps
`default_nettype none
module fdg_tick_gen
   import fdg_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rstn_i,
   fdg_tick_if.gen   tif
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic             tick_q;
   wire              expired = (cnt_q == '0);

   // ==========================================================
   // counter: period is divider + 1 clocks
   assign cnt_d = !tif.run ? tif.div_value
                : expired  ? tif.div_value
                : cnt_q - 11'h001;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tif.run & expired;
      end
   end
   assign tif.tick = tick_q;
endmodule : fdg_tick_gen
`default_nettype wire

// ==== fdg_top.sv ====
// fdg_top: deviation scale/multiplier and gaussian divider registers
// assumes: ahb-lite single word transfers, one clock, sync inputs
//
// Summary of operation
// - bits 7:5 of deviation register scale: /64../1, code 111 x2
// - bits 4:0 of deviation register multiply filter samples
// - filter sample rate comes from an 11-bit software divider
// - divider low byte from own register, bits 10:8 from config
// - deviation = fxosc*(190*mult*2^scale/64+0.5)/(2^21-0.5)
// - gaussian filter is off whenever ask is selected
`timescale 1ns/1ps
`default_nettype none
module fdg_top
   import fdg_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   input  wire logic        filter_sample_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic             filter_enable_o,
   output logic             sample_strobe_o,
   output logic      [12:0] shaped_sample_o
);
   // ==========================================================
   // registers
   logic [7:0]  dev_cfg_q;
   logic [7:0]  div_low_q;
   logic [7:0]  filt_cfg_q;
   logic        wr_pend_q;
   logic [9:0]  wr_addr_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        gf_on_q;
   logic        strobe_q;
   logic [12:0] sample_q;

   fdg_tick_if tif ();

   // ==========================================================
   // fields
   wire [2:0]  deviation_scale      = dev_cfg_q[SCALE_LSB +: 3];
   wire [4:0]  deviation_multiplier = dev_cfg_q[MULT_LSB +: 5];
   wire        filter_bypass        = filt_cfg_q[BYP_BIT];
   wire        ask_select           = filt_cfg_q[ASK_BIT];
   wire [DIV_W-1:0] filter_clock_divider =
      {filt_cfg_q[2:0], div_low_q};
   wire        gf_on_d = !filter_bypass && !ask_select;

   // ==========================================================
   // ahb-lite decode; zero wait states, always okay
   wire        acc     = hsel_i && hready_i && htrans_i[1];
   wire        wr_acc  = acc && hwrite_i;
   wire        rd_acc  = acc && !hwrite_i;
   wire [9:0]  a       = haddr_i[9:0];
   wire        wr_dev  = wr_pend_q && (wr_addr_q == ADDR_DEV_CFG);
   wire        wr_low  = wr_pend_q && (wr_addr_q == ADDR_DIV_LOW);
   wire        wr_filt = wr_pend_q && (wr_addr_q == ADDR_FILT_CFG);

   // unmapped or upper-address reads return zero
   wire        hi_zero = (haddr_i[31:10] == '0);
   assign rdata_d = !(rd_acc && hi_zero)  ? 32'h0000_0000
      : (a == ADDR_DEV_CFG)  ? {24'h000000, dev_cfg_q}
      : (a == ADDR_DIV_LOW)  ? {24'h000000, div_low_q}
      : (a == ADDR_FILT_CFG) ? {24'h000000, filt_cfg_q}
      : (a == ADDR_STATUS)   ? {30'h0, strobe_q, gf_on_q}
      : 32'h0000_0000;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         rdata_q   <= '0;
      end else begin
         wr_pend_q <= wr_acc && hi_zero;
         wr_addr_q <= a;
         rdata_q   <= rdata_d;
      end
   end

   // ==========================================================
   // register writes, data phase
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dev_cfg_q  <= RST_DEV_CFG;
         div_low_q  <= RST_DIV_LOW;
         filt_cfg_q <= RST_FILT_CFG;
      end else begin
         if (wr_dev)
            dev_cfg_q  <= hwdata_i[7:0];
         if (wr_low)
            div_low_q  <= hwdata_i[7:0];
         if (wr_filt)
            filt_cfg_q <= {3'b000, hwdata_i[4:0]};
      end
   end

   // ==========================================================
   // sample strobe generator
   assign tif.div_value = filter_clock_divider;
   assign tif.run       = gf_on_q;

   fdg_tick_gen u_tick (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .tif     (tif)
   );

   // ==========================================================
   // deviation weight: mult * 2^scale / 64, kept as mult << scale
   // so shaped_sample_o carries six fraction bits; code 111 gives x2
   function automatic logic [PROD_W-1:0] dev_weight(
      input logic [4:0] mult,
      input logic [2:0] scale,
      input logic       smp
   );
      logic [PROD_W-1:0] w;
      w = smp ? ({8'h00, mult} << scale) : '0;
      return w;
   endfunction : dev_weight

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gf_on_q  <= 1'b0;
         strobe_q <= 1'b0;
         sample_q <= '0;
      end else begin
         gf_on_q  <= gf_on_d;
         strobe_q <= tif.tick;
         if (tif.tick)
            sample_q <= dev_weight(deviation_multiplier,
                                   deviation_scale,
                                   filter_sample_i);
      end
   end

   assign hrdata_o        = rdata_q;
   assign hreadyout_o     = 1'b1;
   assign hresp_o         = 1'b0;
   assign filter_enable_o = gf_on_q;
   assign sample_strobe_o = strobe_q;
   assign shaped_sample_o = sample_q;
endmodule : fdg_top
`default_nettype wire

// ==== fdg_chk.sv ====
// fdg_chk: port-level assertions for fdg_top
// assumes: bound into fdg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fdg_chk (
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic        filter_sample_i,
   input  wire logic [31:0] hrdata_o,
   input  wire logic        hreadyout_o,
   input  wire logic        hresp_o,
   input  wire logic        filter_enable_o,
   input  wire logic        sample_strobe_o,
   input  wire logic [12:0] shaped_sample_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================================
   // assertions
   AST_ZERO_WAIT: assert property (hreadyout_o && !hresp_o)
      else $error("slave not ready or not okay");
   AST_BYTE_WIDE: assert property (hrdata_o[31:8] == 24'h0)
      else $error("read data above low byte");
   AST_HOLD: assert property ($changed(shaped_sample_o) |-> sample_strobe_o)
      else $error("sample moved without strobe");
   AST_ZERO_IN: assert property (sample_strobe_o && !$past(filter_sample_i)
      |-> shaped_sample_o == 13'h0) else $error("zero input gave nonzero");
   AST_MAX: assert property (shaped_sample_o <= 13'hf80)
      else $error("sample above 31 times 2");
   AST_ASK_OFF: assert property ((!filter_enable_o) [*3]
      |-> !sample_strobe_o) else $error("strobe while filter off");
   AST_STROBE_EN: assert property (sample_strobe_o
      |-> $past(filter_enable_o, 2)) else $error("stray strobe");
endmodule : fdg_chk
bind fdg_top fdg_chk u_chk (.clock_i, .rstn_i, .filter_sample_i, .hrdata_o,
   .hreadyout_o, .hresp_o, .filter_enable_o, .sample_strobe_o, .shaped_sample_o);
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for fdg_top over ahb-lite
// assumes: zero-wait slave, hreadyout fed back as hready
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fdg_pkg::*;
   logic        clock_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0, fs = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0;
   logic [1:0]  htrans_i = 0;
   logic [2:0]  hsize_i = 0;
   wire  [31:0] hrdata;
   wire         hready, hresp, en, stb;
   wire  [12:0] shp;
   int          error_cnt = 0, compares = 0, n;
   // the bench clock stands in for the crystal; one chip is 80 clocks
   localparam int XTAL_HZ               = 100_000_000;
   localparam int CHIP_HZ               = 1_250_000;
   localparam int FILTER_STEPS_PER_CHIP = 16;
   localparam int CHIP_DIV = XTAL_HZ / (CHIP_HZ * FILTER_STEPS_PER_CHIP) - 1;
   fdg_top DUT (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready),
      .filter_sample_i(fs), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .filter_enable_o(en), .sample_strobe_o(stb),
      .shaped_sample_o(shp));
   initial forever #5 clock_i = ~clock_i;
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // master holds each phase until hready is seen high at an edge
   task automatic xfer(input logic [9:0] a, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel_i <= 1;
      haddr_i <= {22'h0, a};
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= wr;
      hsize_i <= HSIZE_WORD;
      do @(posedge clock_i); while (hready !== 1'b1);
      hsel_i <= 0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge clock_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      chk(r, exp);
   endtask : rd
   // cycles until the next strobe, from the current edge
   task automatic wstb();
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (stb !== 1'b1);
   endtask : wstb
   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk({31'h0, en}, 32'h1);
      rd(ADDR_DEV_CFG, 32'hdf);
      rd(ADDR_DIV_LOW, 32'h08);
      rd(ADDR_FILT_CFG, 32'h04);
      rd(10'h080, 32'h0);
   endtask : t_reset
   task automatic t_period();
      wr(ADDR_DIV_LOW, 32'h02);
      wr(ADDR_FILT_CFG, 32'h01);
      repeat (3) wstb();
      chk(n, 259);
      wr(ADDR_DIV_LOW, 32'h03);
      wr(ADDR_FILT_CFG, 32'h00);
      repeat (3) wstb();
      chk(n, 4);
   endtask : t_period
   task automatic t_scale();
      fs <= 1;
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_DEV_CFG, {24'h0, s[2:0], 5'h1f});
         repeat (2) wstb();
         chk({19'h0, shp}, 32'd31 << s);
      end
      wr(ADDR_DEV_CFG, 32'hca);
      repeat (2) wstb();
      // weight carries six fraction bits: 10 x 1 reads as 10 x 64
      chk({19'h0, shp}, 32'h280);
      fs <= 0;
      repeat (2) wstb();
      chk({19'h0, shp}, 32'h0);
   endtask : t_scale
   task automatic t_off(input logic [31:0] cfg);
      wr(ADDR_FILT_CFG, 32'h00);
      wstb();
      chk({31'h0, en}, 32'h1);
      wr(ADDR_FILT_CFG, cfg);
      // a strobe already in the pipe may still show for three edges
      repeat (3) @(posedge clock_i);
      n = 0;
      repeat (30) @(posedge clock_i) n += stb;
      chk({31'h0, en}, 32'h0);
      chk(n, 0);
      rd(ADDR_FILT_CFG, cfg);
      rd(ADDR_STATUS, 32'h0);
   endtask : t_off
   // software picks the divider for 16 filter steps per chip
   task automatic t_chip();
      int tot;
      tot = 0;
      wr(ADDR_DIV_LOW, CHIP_DIV);
      wr(ADDR_FILT_CFG, 32'h00);
      repeat (2) wstb();
      repeat (FILTER_STEPS_PER_CHIP) begin
         wstb();
         tot += n;
      end
      chk(tot, XTAL_HZ / CHIP_HZ);
   endtask : t_chip
   // ==========================================================
   // run control
   task automatic end_sim();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial begin
      // whole run needs well under 5000 cycles
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clock_i);
      rstn_i <= 1;
      repeat (2) @(posedge clock_i);
      t_reset();
      t_period();
      t_scale();
      t_off(32'h08);
      t_off(32'h10);
      t_chip();
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
